// *** core/fcr_top.sv ***
// Operation
// - Wrap select 0: burst address returns to 0x02 after 0x07.
// - Wrap select 1: burst address returns to 0x02 after 0x09.
// - FIFO burst 0: one six-byte sample per read transaction.
// - FIFO burst 1: burst continues through samples, whole FIFO readable.
// - SPI token bit 1: status flags shift out in first 4-wire SPI byte.
// - SPI token ignored in 3-wire SPI and I2C; bit 0 never shifts flags.
// - Token on, resolution under 14: flags in Z top nibble, then Z[11:0].
// - Token on, resolution 14 or more: Z[15:4] then flags in bottom nibble.
// - Token off returns Z unmodified; token works in all interface modes.
// - I2C with write-clear 0: reading 0x09 clears pending interrupts.
// - Write-clear 1 and I2C enabled: any 0x09 write clears; reads do not.
// - Write-clear 1 without I2C enabled: I2C reads of 0x09 still clear.
// - SPI ignores write-clear; host writes 0x09 to clear interrupts.
// - Stream mode: full FIFO drops oldest sample to store new one.
// - Stream off: full FIFO stops accepting new samples.
// - Stream mode acts only while FIFO enable is set.
// - Edge select 0 triggers on falling edge, 1 on rising edge.
// - Outside trigger enable turns interrupt pin into trigger input.
// - Counted mode takes 1 to 254 samples or endless, then holds in low power until the mode changes.
// - Threshold flag set when stored count reaches programmed threshold.
`timescale 1ns/1ps

module fcr_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 32
) (
    input  wire logic                       clock_i,   // Core clock
    input  wire logic                       rst_n_i,   // Async reset
    input  wire logic                       in_valid_i, // Push request
    output logic                            in_ready_o, // Room or pop this cycle
    input  wire logic [WIDTH-1:0]           in_data_i, // Pushed word
    output logic                            out_valid_o, // Head present
    input  wire logic                       out_ready_i, // Pop head
    output logic [WIDTH-1:0]                out_data_o, // Head word
    output logic [$clog2(DEPTH+1)-1:0]      count_o    // Words stored
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic             push;
    logic             pop;

    // A full FIFO still accepts a word when the head leaves in the same cycle
    assign out_valid_o = (count_o != '0);
    assign in_ready_o  = (count_o != ($clog2(DEPTH+1))'(DEPTH)) || out_ready_i;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem_reg[rd_ptr_reg];

    // Storage array
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_o    <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_o <= count_o + ($clog2(DEPTH+1))'(push) - ($clog2(DEPTH+1))'(pop);
        end
    end
endmodule : fcr_fifo

module fcr_top import fcr_pkg::*; #(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic                    clock_i,         // 100 MHz core clock
    input  wire logic                    rst_n_i,         // Async reset
    input  wire logic                    wr_strobe_i,     // Register write
    input  wire logic [7:0]              wr_addr_i,       // Write address
    input  wire logic [7:0]              wr_data_i,       // Write data
    input  wire logic                    burst_start_i,   // Load read address
    input  wire logic [7:0]              start_addr_i,    // First read address
    input  wire logic                    rd_strobe_i,     // Read byte, then advance
    output logic [7:0]                   rd_data_o,       // Read byte
    output logic [7:0]                   rd_addr_o,       // Current read address
    input  wire logic                    link_is_i2c_i,   // Transfer is on I2C
    input  wire logic                    link_is_spi3_i,  // SPI runs 3-wire
    input  wire logic                    i2c_enable_i,    // I2C select bit
    input  wire logic                    fifo_enable_i,   // FIFO enable bit
    input  wire logic                    res_ge14_i,      // Resolution 14 bits or more
    input  wire logic [4:0]              threshold_i,     // FIFO threshold count
    input  wire logic [2:0]              mode_select_field_i, // Mode control field
    input  wire logic [7:0]              counted_sampling_mode_count_i,    // Samples per trigger run
    input  wire logic                    sample_tick_i,   // Internal sample tick
    input  wire logic [7:0]              status_one_i,    // Status byte 0x08
    input  wire logic [7:0]              status_two_i,    // Status byte 0x09
    input  wire logic                    irq_pending_flag_i, // Any interrupt pending
    input  wire logic                    irq_request_i,   // Interrupt to signal
    input  wire logic                    sample_valid_i,  // New XYZ sample
    output logic                         sample_ready_o,  // FIFO takes sample
    input  wire logic [SAMPLE_WIDTH-1:0] sample_data_i,   // {Z,Y,X}
    input  wire logic                    interrupt_pin_low_active_i, // Pin level in
    output logic                         interrupt_pin_low_active_o, // Pin level out
    output logic                         interrupt_pin_low_active_oe_o, // Pin drive
    output logic                         irq_clear_o,     // Clear pending interrupts
    output logic                         spi_token_en_o,  // Shift token on first byte
    output logic [7:0]                   spi_token_o,     // Status token byte
    output logic                         queue_threshold_flag_o, // Count >= threshold
    output logic                         sample_request_o, // Acquire one sample
    output logic                         low_power_o      // Counted run finished
);
    logic [7:0]              feature_control_two_reg;
    logic [7:0]              addr_reg;
    logic                    popped_reg;
    logic [2:0]              pin_sync_reg;
    logic [7:0]              taken_reg;
    fcr_counted_sampling_mode_state_t         counted_sampling_mode_state_reg;
    logic                    fifo_in_ready;
    logic                    fifo_valid;
    logic [SAMPLE_WIDTH-1:0] head;
    logic [$clog2(DEPTH+1)-1:0] fill;
    logic                    fifo_full;
    logic                    fifo_empty;
    logic                    stream_on;
    logic                    drop_old;
    logic                    burst_pop;
    logic                    pop;
    logic [3:0]              flags;
    logic [15:0]             z_word;
    logic [7:0]              rd_byte;
    logic                    wrap_here;
    logic                    edge_seen;

    // Named bits of the feature register
    logic burst_wrap_select;
    logic fifo_burst;
    logic spi_status_token;
    logic fifo_status_token;
    logic irq_clear_on_write;
    logic fifo_stream;
    logic outside_trigger_edge_select;
    logic outside_trigger_enable;
    assign burst_wrap_select           = feature_control_two_reg[BURST_WRAP_SELECT_BIT];
    assign fifo_burst                  = feature_control_two_reg[FIFO_BURST_BIT];
    assign spi_status_token            = feature_control_two_reg[SPI_STATUS_TOKEN_BIT];
    assign fifo_status_token           = feature_control_two_reg[FIFO_STATUS_TOKEN_BIT];
    assign irq_clear_on_write          = feature_control_two_reg[IRQ_CLEAR_ON_WRITE_BIT];
    assign fifo_stream                 = feature_control_two_reg[FIFO_STREAM_BIT];
    assign outside_trigger_edge_select = feature_control_two_reg[OUTSIDE_COUNTED_SAMPLING_MODE_EDGE_BIT];
    assign outside_trigger_enable      = feature_control_two_reg[OUTSIDE_COUNTED_SAMPLING_MODE_EN_BIT];

    // Feature register store
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            feature_control_two_reg <= FEATURE_CONTROL_TWO_RST;
        end else if (wr_strobe_i && wr_addr_i == FEATURE_CONTROL_TWO_ADDR) begin
            feature_control_two_reg <= wr_data_i;
        end
    end

    // Sample buffer; a full buffer backs the source off unless streaming
    fcr_fifo #(
        .WIDTH (SAMPLE_WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (sample_valid_i),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (sample_data_i),
        .out_valid_o (fifo_valid),
        .out_ready_i (pop),
        .out_data_o  (head),
        .count_o     (fill)
    );
    assign fifo_full      = (fill == ($clog2(DEPTH+1))'(DEPTH));
    assign fifo_empty     = !fifo_valid;
    assign stream_on      = fifo_stream && fifo_enable_i;
    assign drop_old       = stream_on && fifo_full && sample_valid_i;
    assign pop            = burst_pop || drop_old;
    assign sample_ready_o = fifo_in_ready;
    // Both sides widened so a threshold above a small depth never wraps
    assign queue_threshold_flag_o = (8'(fill) >= 8'(threshold_i));

    // Z word with optional status token
    assign flags = {irq_pending_flag_i, queue_threshold_flag_o, fifo_full, fifo_empty};
    always_comb begin
        z_word = head[47:32];
        if (fifo_status_token) begin
            z_word = res_ge14_i ? {head[47:36], flags}
                                : {flags, head[43:32]};
        end
    end

    // Byte at the current read address
    always_comb begin
        case (addr_reg)
            8'h02:           rd_byte = head[7:0];
            8'h03:           rd_byte = head[15:8];
            8'h04:           rd_byte = head[23:16];
            8'h05:           rd_byte = head[31:24];
            8'h06:           rd_byte = z_word[7:0];
            8'h07:           rd_byte = z_word[15:8];
            STATUS_ONE_ADDR: rd_byte = status_one_i;
            IRQ_STATUS_ADDR: rd_byte = status_two_i;
            FEATURE_CONTROL_TWO_ADDR: rd_byte = feature_control_two_reg;
            default:         rd_byte = 8'h00;
        endcase
    end

    // Wrap point of the burst address counter
    assign wrap_here = burst_wrap_select ? (addr_reg == BURST_LONG_END)
                                         : (addr_reg == BURST_SHORT_END);
    // Last Z byte retires a sample; one per transaction unless FIFO burst
    assign burst_pop = rd_strobe_i && addr_reg == BURST_SHORT_END && fifo_valid
                       && (fifo_burst || !popped_reg);

    // Burst address counter and read data
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_reg   <= BURST_FIRST_ADDR;
            popped_reg <= 1'b0;
            rd_data_o  <= 8'h00;
        end else if (burst_start_i) begin
            addr_reg   <= start_addr_i;
            popped_reg <= 1'b0;
        end else if (rd_strobe_i) begin
            rd_data_o <= rd_byte;
            addr_reg  <= wrap_here ? BURST_FIRST_ADDR : addr_reg + 8'h01;
            if (burst_pop) begin
                popped_reg <= 1'b1;
            end
        end
    end
    assign rd_addr_o = addr_reg;

    // Interrupt clearing: SPI, and I2C with write-clear and I2C select both set, clear on write; else on read
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_clear_o <= 1'b0;
        end else if (!link_is_i2c_i) begin
            irq_clear_o <= wr_strobe_i && wr_addr_i == IRQ_STATUS_ADDR;
        end else if (irq_clear_on_write && i2c_enable_i) begin
            irq_clear_o <= wr_strobe_i && wr_addr_i == IRQ_STATUS_ADDR;
        end else begin
            irq_clear_o <= rd_strobe_i && addr_reg == IRQ_STATUS_ADDR;
        end
    end

    // SPI status token; 3-wire SPI and I2C never see it
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            spi_token_en_o <= 1'b0;
            spi_token_o    <= 8'h00;
        end else begin
            spi_token_en_o <= spi_status_token && !link_is_i2c_i && !link_is_spi3_i;
            spi_token_o    <= {flags, TOKEN_PAD};
        end
    end

    // Pin is an input while outside triggering is on, else drives the interrupt
    assign interrupt_pin_low_active_oe_o = !outside_trigger_enable;
    assign interrupt_pin_low_active_o    = !irq_request_i;

    // Two-stage synchroniser plus an edge history stage
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_sync_reg <= 3'b111;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], interrupt_pin_low_active_i};
        end
    end
    // Only stages two and three are compared, so one edge is seen once
    assign edge_seen = outside_trigger_enable &&
                       (outside_trigger_edge_select ? (pin_sync_reg[1] && !pin_sync_reg[2])
                                                    : (!pin_sync_reg[1] && pin_sync_reg[2]));

    // Counted sampling sequencer; endless when the count is all ones
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            counted_sampling_mode_state_reg   <= TRG_IDLE;
            taken_reg        <= 8'h00;
            sample_request_o <= 1'b0;
            low_power_o      <= 1'b0;
        end else begin
            sample_request_o <= 1'b0;
            case (counted_sampling_mode_state_reg)
                TRG_IDLE: begin
                    low_power_o <= 1'b0;
                    taken_reg   <= 8'h00;
                    if (mode_select_field_i == COUNTED_MODE_CODE && counted_sampling_mode_count_i != 8'h00) begin
                        counted_sampling_mode_state_reg <= TRG_RUN;
                    end
                end
                TRG_RUN: begin
                    if (mode_select_field_i != COUNTED_MODE_CODE) begin
                        counted_sampling_mode_state_reg <= TRG_IDLE;
                    end else if (outside_trigger_enable ? edge_seen : sample_tick_i) begin
                        sample_request_o <= 1'b1;
                        if (counted_sampling_mode_count_i != ENDLESS_COUNT) begin
                            taken_reg <= taken_reg + 8'h01;
                            if (taken_reg + 8'h01 >= counted_sampling_mode_count_i) begin
                                counted_sampling_mode_state_reg <= TRG_DONE;
                            end
                        end
                    end
                end
                TRG_DONE: begin
                    low_power_o <= 1'b1;
                    if (mode_select_field_i != COUNTED_MODE_CODE) begin
                        counted_sampling_mode_state_reg <= TRG_IDLE;
                    end
                end
                default: counted_sampling_mode_state_reg <= TRG_IDLE;
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_read_at(logic [7:0] a);
        rd_strobe_i && !burst_start_i && addr_reg == a;
    endsequence
    sequence s_pin_fall;
        outside_trigger_enable && !outside_trigger_edge_select
        && pin_sync_reg[2:1] == 2'b11 ##1 pin_sync_reg[2:1] == 2'b10;
    endsequence

    AST_WRAP_SHORT: assert property (s_read_at(BURST_SHORT_END) ##0 !burst_wrap_select
        |=> addr_reg == BURST_FIRST_ADDR) else $error("short wrap missed");
    AST_WRAP_LONG: assert property (s_read_at(BURST_SHORT_END) ##0 burst_wrap_select
        |=> addr_reg == STATUS_ONE_ADDR ##1 1'b1) else $error("long wrap too early");
    AST_ONE_SAMPLE: assert property (popped_reg && !fifo_burst && !drop_old
        |=> fill >= $past(fill)) else $error("second sample popped");
    AST_MANY_SAMPLE: assert property (s_read_at(BURST_SHORT_END) ##0 fifo_burst
        && fifo_valid |-> burst_pop) else $error("FIFO burst stalled");
    AST_SPI_TOKEN: assert property (link_is_i2c_i || link_is_spi3_i || !spi_status_token
        |=> !spi_token_en_o) else $error("token outside 4-wire SPI");
    AST_TOKEN_LOW: assert property (fifo_status_token && !res_ge14_i
        |-> z_word[15:12] == flags) else $error("token not in top nibble");
    AST_CLR_READ: assert property (s_read_at(IRQ_STATUS_ADDR)
        ##0 (link_is_i2c_i && !irq_clear_on_write) |=> irq_clear_o)
        else $error("read did not clear");
    AST_CLR_WRITE: assert property (link_is_i2c_i && irq_clear_on_write && i2c_enable_i
        && !wr_strobe_i |=> !irq_clear_o) else $error("clear without write");
    AST_FULL_STOP: assert property (fifo_full && !stream_on && !burst_pop
        |-> !sample_ready_o) else $error("full FIFO accepted sample");
    AST_STREAM_DROP: assert property (fifo_full && stream_on && sample_valid_i
        |-> pop && sample_ready_o ##1 fifo_full) else $error("stream did not replace");
    AST_EDGE_ONCE: assert property (s_pin_fall ##0 counted_sampling_mode_state_reg == TRG_RUN
        && mode_select_field_i == COUNTED_MODE_CODE |=> sample_request_o ##1 !sample_request_o)
        else $error("edge gave wrong request count");
endmodule : fcr_top

// *** include/fcr_pkg.sv ***
package fcr_pkg;
    // Register offsets and feature register reset value
    localparam logic [7:0] FEATURE_CONTROL_TWO_ADDR = 8'h0e;
    localparam logic [7:0] IRQ_STATUS_ADDR          = 8'h09;
    localparam logic [7:0] BURST_FIRST_ADDR         = 8'h02;
    localparam logic [7:0] BURST_SHORT_END          = 8'h07;
    localparam logic [7:0] BURST_LONG_END           = 8'h09;
    localparam logic [7:0] STATUS_ONE_ADDR          = 8'h08;
    localparam logic [7:0] FEATURE_CONTROL_TWO_RST  = 8'h00;
    // Field positions in feature_control_two
    localparam int BURST_WRAP_SELECT_BIT  = 0;
    localparam int FIFO_BURST_BIT         = 1;
    localparam int SPI_STATUS_TOKEN_BIT   = 2;
    localparam int FIFO_STATUS_TOKEN_BIT  = 3;
    localparam int IRQ_CLEAR_ON_WRITE_BIT = 4;
    localparam int FIFO_STREAM_BIT        = 5;
    localparam int OUTSIDE_COUNTED_SAMPLING_MODE_EDGE_BIT  = 6;
    localparam int OUTSIDE_COUNTED_SAMPLING_MODE_EN_BIT    = 7;
    // Sampling and FIFO figures
    localparam int          SAMPLE_WIDTH      = 48;
    localparam int          FIFO_DEPTH        = 32;
    localparam logic [2:0]  COUNTED_MODE_CODE = 3'b111;
    localparam logic [7:0]  ENDLESS_COUNT     = 8'hff;
    localparam logic [3:0]  TOKEN_PAD         = 4'h0;
    // Counted-sampling sequencer states
    typedef enum logic [1:0] {
        TRG_IDLE = 2'b00,
        TRG_RUN  = 2'b01,
        TRG_DONE = 2'b10
    } fcr_counted_sampling_mode_state_t;
endpackage : fcr_pkg

// *** sim/fcr_host_model.sv ***
`timescale 1ns/1ps
module fcr_host_model import fcr_pkg::*; (
    input  wire logic       clock_i, // Core clock
    output logic            pin_o,   // Trigger pin drive
    output logic [2:0]      mode_o,  // Mode field
    output logic [7:0]      count_o  // Samples per run
);
    // Pin idles high as the pull-up would hold it between frames
    initial begin
        pin_o = 1'b1;
        mode_o = 3'h0;
        count_o = 8'h00;
    end
    // Runs start from the mode field only, never from a one-shot command
    task automatic start_run(input logic [7:0] n);
        @(negedge clock_i);
        mode_o = 3'h0;
        count_o = n;
        @(negedge clock_i);
        mode_o = COUNTED_MODE_CODE;
    endtask : start_run
    // 80 ns link period, offset from the core clock; ends high again
    task automatic edges(input int n);
        #3;
        repeat (2 * n) #40 pin_o = ~pin_o;
    endtask : edges
endmodule : fcr_host_model

// *** sim/fcr_top_tb.sv ***
`timescale 1ns/1ps
module fcr_top_tb;
    logic        clock_i, rst_n, wr_s, bs, rs, l_i2c, l_spi3, i2c_en, f_en, res14, s_v;
    logic        s_r, pin_out, pin_oe, clr, tok_en, thr_f, req, lp, h_pin, irq_req, pend;
    logic [7:0]  wr_a, wr_d, sa, rdd, rda, tcnt, tok;
    logic [2:0]  mode;
    logic [4:0]  thr;
    logic [47:0] s_d;
    logic [7:0]  q [12];
    int          error_cnt, total_checks, req_cnt;
    wire         pin_w = pin_oe ? pin_out : h_pin;
    typedef struct packed {
        logic [7:0] cfg; // Feature register value
        logic [3:0] ctl; // {i2c link, i2c select, 3-wire, write}
        logic [7:0] a;   // Address accessed
        logic [1:0] ex;  // {clear pulse, token enable}
        logic [7:0] nxt; // Read address afterwards
    } fcr_row_t;
    fcr_row_t rows [10] = '{'{8'h00, 4'h8, 8'h09, 2'h2, 8'h0a}, '{8'h10, 4'hc, 8'h09, 2'h0, 8'h0a},
        '{8'h10, 4'hd, 8'h09, 2'h2, 8'h00}, '{8'h10, 4'h8, 8'h09, 2'h2, 8'h0a},
        '{8'h00, 4'h0, 8'h09, 2'h0, 8'h0a}, '{8'h00, 4'h1, 8'h09, 2'h2, 8'h00},
        '{8'h04, 4'h0, 8'h07, 2'h1, 8'h02}, '{8'h05, 4'h2, 8'h07, 2'h0, 8'h08},
        '{8'h01, 4'h0, 8'h09, 2'h0, 8'h02}, '{8'h04, 4'h8, 8'h03, 2'h0, 8'h04}};
    fcr_top #(.DEPTH(4)) fcr_top_inst (
        .clock_i(clock_i), .rst_n_i(rst_n), .wr_strobe_i(wr_s), .wr_addr_i(wr_a),
        .wr_data_i(wr_d), .burst_start_i(bs), .start_addr_i(sa), .rd_strobe_i(rs),
        .rd_data_o(rdd), .rd_addr_o(rda), .link_is_i2c_i(l_i2c), .link_is_spi3_i(l_spi3),
        .i2c_enable_i(i2c_en), .fifo_enable_i(f_en), .res_ge14_i(res14), .threshold_i(thr),
        .mode_select_field_i(mode), .counted_sampling_mode_count_i(tcnt), .sample_tick_i(1'b0),
        .status_one_i(8'h81), .status_two_i(8'h42), .irq_pending_flag_i(pend),
        .irq_request_i(irq_req), .sample_valid_i(s_v), .sample_ready_o(s_r), .sample_data_i(s_d),
        .interrupt_pin_low_active_i(pin_w), .interrupt_pin_low_active_o(pin_out),
        .interrupt_pin_low_active_oe_o(pin_oe), .irq_clear_o(clr), .spi_token_en_o(tok_en),
        .spi_token_o(tok), .queue_threshold_flag_o(thr_f), .sample_request_o(req),
        .low_power_o(lp));
    fcr_host_model fcr_host_model_inst (.clock_i(clock_i), .pin_o(h_pin), .mode_o(mode),
        .count_o(tcnt));
    // Free-running 100 MHz clock
    always #5 clock_i = ~clock_i;
    // Count trigger requests; one pin edge must give exactly one
    always @(posedge clock_i) if (req === 1'b1) req_cnt++;
    task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        {wr_s, wr_a, wr_d} = {1'b1, a, d};
        @(negedge clock_i);
        wr_s = 1'b0;
    endtask : wr
    // Strobe held high across bytes so reads run back to back
    task automatic rd(input logic [7:0] a, input int n);
        @(negedge clock_i);
        {bs, sa} = {1'b1, a};
        @(negedge clock_i);
        bs = 1'b0;
        for (int i = 0; i < n; i++) begin
            rs = 1'b1;
            @(negedge clock_i);
            q[i] = rdd;
        end
        rs = 1'b0;
    endtask : rd
    function automatic logic [47:0] smp(input logic [3:0] k);
        return {12'h3c5, k, 12'h2b0, k, 12'h1a0, k};
    endfunction : smp
    task automatic push(input logic [3:0] k);
        @(negedge clock_i);
        {s_v, s_d} = {1'b1, smp(k)};
        @(negedge clock_i);
        s_v = 1'b0;
    endtask : push
    // Six bytes at q[o] against one sample, low byte first
    task automatic chk_smp(input logic [47:0] s, input int o);
        chk("x_word", {q[o+1], q[o]}, s[15:0]);
        chk("y_word", {q[o+3], q[o+2]}, s[31:16]);
        chk("z_word", {q[o+5], q[o+4]}, s[47:32]);
    endtask : chk_smp
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    // Watchdog at 10000 cycles, well past the roughly 200 cycles the tests need
    initial begin
        #100000;
        error_cnt++;
        end_of_test();
    end
    // Main sequence: reset and register checks, table, then FIFO and trigger cases
    initial begin
        clock_i = 1'b0;
        {rst_n, wr_s, bs, rs, l_i2c, l_spi3, i2c_en, f_en, res14, s_v} = '0;
        {wr_a, wr_d, sa, s_d} = '0;
        thr = 5'h04;
        {irq_req, pend} = 2'b11;
        repeat (8) @(negedge clock_i);
        rst_n = 1'b1;
        chk("rst_addr", rda, 8'h02);
        chk("rst_pin_oe", pin_oe, 1'b1);
        chk("pin_level", pin_w, 1'b0);
        irq_req = 1'b0;
        #1 chk("pin_idle", pin_w, 1'b1);
        irq_req = 1'b1;
        rd(8'h0e, 1);
        chk("reg_reset", rdd, 8'h00);
        chk("spi_token", tok, 8'h90);
        pend = 1'b0;
        @(negedge clock_i);
        chk("token_pend", tok, 8'h10);
        pend = 1'b1;
        wr(8'h0e, 8'h3c);
        rd(8'h0e, 1);
        chk("reg_rw", rdd, 8'h3c);
        rd(8'h20, 1);
        chk("unmapped", rdd, 8'h00);
        foreach (rows[k]) begin
            wr(8'h0e, rows[k].cfg);
            {l_i2c, i2c_en, l_spi3} = rows[k].ctl[3:1];
            if (rows[k].ctl[0]) wr(rows[k].a, 8'h5a);
            else rd(rows[k].a, 1);
            chk("irq_clear", clr, rows[k].ex[1]);
            if (!rows[k].ctl[0]) chk("rd_addr", rda, rows[k].nxt);
            chk("spi_token_en", tok_en, rows[k].ex[0]);
        end
        rd(8'h08, 2);
        chk("status_one", q[0], 8'h81);
        chk("status_two", q[1], 8'h42);
        wr(8'h0e, 8'h00);
        for (int k = 0; k < 5; k++) push(4'(k));
        chk("ready_full", s_r, 1'b0);
        chk("thresh_full", thr_f, 1'b1);
        wr(8'h0e, 8'h08);
        res14 = 1'b1;
        rd(8'h02, 6);
        chk_smp(smp(4'h0) | 48'h000e00000000, 0);
        push(4'h4);
        wr(8'h0e, 8'h20);
        // Ready only answers a standing sample, so valid is raised first
        {s_v, s_d} = {1'b1, smp(4'h5)};
        #1 chk("ready_no_fifo", s_r, 1'b0);
        @(negedge clock_i);
        f_en = 1'b1;
        #1 chk("ready_stream", s_r, 1'b1);
        @(negedge clock_i);
        s_v = 1'b0;
        wr(8'h0e, 8'h22);
        rd(8'h02, 12);
        chk_smp(smp(4'h2), 0);
        chk_smp(smp(4'h3), 6);
        rd(8'h02, 12);
        chk_smp(smp(4'h4), 0);
        chk_smp(smp(4'h5), 6);
        chk("thresh_empty", thr_f, 1'b0);
        // Falling then rising polarity; three pin pulses each time
        for (int p = 0; p < 2; p++) begin
            wr(8'h0e, p[0] ? 8'hc0 : 8'h80);
            chk("pin_oe_counted_sampling_mode", pin_oe, 1'b0);
            fcr_host_model_inst.start_run(8'(2 + p));
            req_cnt = 0;
            fcr_host_model_inst.edges(3);
            repeat (8) @(negedge clock_i);
            chk("requests", 8'(req_cnt), 8'(2 + p));
            chk("low_power", lp, 1'b1);
        end
        // Mid-run reset must drop the finished run and the trigger setup
        @(negedge clock_i);
        rst_n = 1'b0;
        @(negedge clock_i);
        chk("rst_mid_lp", lp, 1'b0);
        chk("rst_mid_oe", pin_oe, 1'b1);
        rst_n = 1'b1;
        end_of_test();
    end
endmodule : fcr_top_tb
